/* File: hdl/bbp_pkg.sv */
// Shared constants for the backplane block pager and its host end
`default_nettype none
package bbp_pkg;
  localparam int WORD_W = 16;
  localparam int DB_DEPTH = 8000;
  localparam int HOST_DEPTH = 1024;
  // Database map
  localparam logic [12:0] USER_LAST = 13'h1387;
  localparam logic [12:0] CFG_FIRST = 13'h1388;
  localparam logic [12:0] CFG_LAST  = 13'h1f3f;
  localparam logic [12:0] SLV1_BASE = 13'h1770;
  localparam logic [12:0] SLV2_BASE = 13'h189c;
  // Payload settings and image headers
  localparam logic [1:0] SZ_60  = 2'h0;
  localparam logic [1:0] SZ_120 = 2'h1;
  localparam logic [1:0] SZ_240 = 2'h2;
  localparam logic [7:0] PAY_60  = 8'h3c;
  localparam logic [7:0] PAY_120 = 8'h78;
  localparam logic [7:0] PAY_240 = 8'hf0;
  localparam logic [7:0] IN_HDR  = 8'h02;
  localparam logic [7:0] OUT_HDR = 8'h01;
  localparam logic [7:0] MAX_WR  = 8'hc8;
  localparam logic [7:0] SLV_WORDS = 8'h3c;
  // Block codes
  localparam logic [15:0] C_STAT_M1   = 16'hffff;
  localparam logic [15:0] C_STAT0     = 16'h0000;
  localparam logic [15:0] C_DATA_LAST = 16'h03e7;
  localparam logic [15:0] C_EV1       = 16'h03e8;
  localparam logic [15:0] C_EV2       = 16'h07d0;
  localparam logic [15:0] C_POLL1     = 16'h0bb8;
  localparam logic [15:0] C_POLL1_END = 16'h0bb9;
  localparam logic [15:0] C_SS1       = 16'h0bba;
  localparam logic [15:0] C_SS1_END   = 16'h0bbe;
  localparam logic [15:0] C_POLL2     = 16'h0c1c;
  localparam logic [15:0] C_POLL2_END = 16'h0c1d;
  localparam logic [15:0] C_SS2       = 16'h0c1e;
  localparam logic [15:0] C_SS2_END   = 16'h0c22;
  localparam logic [15:0] C_CMD1      = 16'h1388;
  localparam logic [15:0] C_CMD1_END  = 16'h138e;
  localparam logic [15:0] C_CMD2      = 16'h13ec;
  localparam logic [15:0] C_CMD2_END  = 16'h13f2;
  localparam logic [15:0] C_TSET      = 16'h26f4;
  localparam logic [15:0] C_TGET      = 16'h26f5;
  localparam logic [15:0] C_WARM      = 16'h270e;
  localparam logic [15:0] C_COLD      = 16'h270f;
  // Host register map
  localparam logic [1:0]  HR_TX_SEL = 2'h0;
  localparam logic [1:0]  HR_RX_SEL = 2'h1;
  localparam logic [11:0] HR_SPEC   = 12'h800;
  localparam logic [11:0] HR_STAT   = 12'h801;
  localparam logic [11:0] HR_COUNT  = 12'h802;
  localparam logic [11:0] HR_LAST   = 12'h803;

  // Payload words for a size setting
  function automatic logic [7:0] pay_len(input logic [1:0] sel);
    case (sel)
      SZ_120:  pay_len = PAY_120;
      SZ_240:  pay_len = PAY_240;
      default: pay_len = PAY_60;
    endcase
  endfunction : pay_len
endpackage : bbp_pkg
`default_nettype wire

/* File: hdl/bbp_link_if.sv */
// Word link carrying input and output images across the backplane
`default_nettype none
interface bbp_link_if;
  logic        in_valid;
  logic [15:0] in_data;
  logic        in_last;
  logic        out_valid;
  logic [15:0] out_data;
  logic        out_last;
  modport dev (output in_valid, in_data, in_last, input out_valid, out_data, out_last);
  modport host (input in_valid, in_data, in_last, output out_valid, out_data, out_last);
endinterface : bbp_link_if
`default_nettype wire

/* File: hdl/bbp_host.sv */
// Host end: stores uploaded pages and sends download pages
`default_nettype none
module bbp_host (
  input  wire logic        clk,
  input  wire logic        nrst,
  bbp_link_if.host         link,
  input  wire logic [1:0]  cfg_size,
  input  wire logic [11:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata
);
  typedef enum logic [1:0] {H_RX = 2'b01, H_TX = 2'b10} bbp_hstate_type;
  typedef struct packed {
    bbp_hstate_type st;
    logic [7:0]     cnt;
    logic [7:0]     n;
    logic [15:0]    up;
    logic [15:0]    dn;
    logic [15:0]    tcode;
    logic           spec_pend;
    logic [15:0]    spec_code;
    logic [15:0]    img_cnt;
    logic           out_valid;
    logic           out_last;
    logic [15:0]    out_data;
    logic [15:0]    rdata;
  } bbp_host_type;

  bbp_host_type s_reg;
  bbp_host_type s_next;
  logic [15:0]  rx_mem [0:bbp_pkg::HOST_DEPTH-1];
  logic [15:0]  tx_mem [0:bbp_pkg::HOST_DEPTH-1];
  logic         rx_we;
  logic [9:0]   rx_wa;
  logic [19:0]  off;
  logic [7:0]   k;

  // Image framing, page storage and software port
  always_comb begin
    s_next = s_reg;
    s_next.out_valid = 1'b0;
    s_next.out_last = 1'b0;
    rx_we = 1'b0;
    rx_wa = '0;
    off = '0;
    k = '0;
    if (rd) begin
      case (addr[11:10])
        bbp_pkg::HR_TX_SEL: s_next.rdata = tx_mem[addr[9:0]];
        bbp_pkg::HR_RX_SEL: s_next.rdata = rx_mem[addr[9:0]];
        default: begin
          case (addr)
            bbp_pkg::HR_SPEC:  s_next.rdata = s_reg.spec_code;
            bbp_pkg::HR_STAT:  s_next.rdata = {15'h0000, s_reg.spec_pend};
            bbp_pkg::HR_COUNT: s_next.rdata = s_reg.img_cnt;
            bbp_pkg::HR_LAST:  s_next.rdata = s_reg.up;
            default:           s_next.rdata = '0;
          endcase
        end
      endcase
    end
    case (s_reg.st)
      H_RX: begin
        if (link.in_valid) begin
          s_next.cnt = s_reg.cnt + 8'h01;
          k = s_reg.cnt - bbp_pkg::IN_HDR;
          if (s_reg.cnt == 8'h00) begin
            s_next.up = link.in_data;
            s_next.n = bbp_pkg::pay_len(cfg_size); // R02
          end else if (s_reg.cnt == 8'h01) begin
            s_next.dn = link.in_data;
          end else if (s_reg.up != 16'h0000 && s_reg.up <= bbp_pkg::C_DATA_LAST) begin
            // Upload index picks the slot in the received array
            off = 20'((s_reg.up - 16'h0001) * s_reg.n) + {12'h000, k}; // R06
            rx_we = (off < 20'(bbp_pkg::HOST_DEPTH));
            rx_wa = off[9:0];
          end
          if (link.in_last) begin
            s_next.cnt = '0;
            s_next.st = H_TX;
          end
        end
      end
      H_TX: begin
        s_next.out_valid = 1'b1;
        s_next.cnt = s_reg.cnt + 8'h01;
        k = s_reg.cnt - bbp_pkg::OUT_HDR;
        if (s_reg.cnt == 8'h00) begin
          // A queued special code replaces the requested index once
          s_next.tcode = s_reg.spec_pend ? s_reg.spec_code : s_reg.dn;
          s_next.out_data = s_next.tcode; // R07
          s_next.spec_pend = 1'b0;
        end else begin
          if (s_reg.tcode != 16'h0000 && s_reg.tcode <= bbp_pkg::C_DATA_LAST) begin
            off = 20'((s_reg.tcode - 16'h0001) * s_reg.n) + {12'h000, k};
          end else begin
            off = {12'h000, k};
          end
          s_next.out_data = (off < 20'(bbp_pkg::HOST_DEPTH)) ? tx_mem[off[9:0]] : '0; // R07
        end
        if (s_reg.cnt == s_reg.n) begin
          s_next.out_last = 1'b1; // R04
          s_next.cnt = '0;
          s_next.img_cnt = s_reg.img_cnt + 16'h0001;
          s_next.st = H_RX;
        end
      end
      default: s_next.st = H_RX;
    endcase
    // Software write queues a special code; the set wins over the send
    if (wr && addr == bbp_pkg::HR_SPEC) begin
      s_next.spec_code = wdata;
      s_next.spec_pend = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.st <= H_RX;
    end else begin
      s_reg <= s_next;
    end
  end

  // Page arrays; no reset, contents are data only
  always_ff @(posedge clk) begin
    if (rx_we) begin
      rx_mem[rx_wa] <= link.in_data;
    end
    if (wr && addr[11:10] == bbp_pkg::HR_TX_SEL) begin
      tx_mem[addr[9:0]] <= wdata;
    end
  end

  assign link.out_valid = s_reg.out_valid;
  assign link.out_data  = s_reg.out_data;
  assign link.out_last  = s_reg.out_last;
  assign rdata          = s_reg.rdata;
endmodule : bbp_host
`default_nettype wire

/* File: hdl/bbp_device.sv */
// Device end: paged word database behind the backplane images
//
// The placing of the registers and strobed register access are this design's own decisions.
`default_nettype none
// What this block does
// (R01) Database: 0-4999 user, 5000-7999 configuration/status
// (R02) Payload 60, 120 or 240, same both ends
// (R03) Input image is payload plus two words
// (R04) Output image is payload plus one word
// (R05) Input image: upload index, download index, payload
// (R06) Host files payload by upload index
// (R07) Output image: download index then payload
// (R08) Download index places payload; at most 200 words
// (R09) Both indices step and wrap independently
// (R10) Other index or command request breaks sequence; a request pending when a special reply is due is dropped
// (R11) Codes -1,0 status; 1-999 data pages
// (R12) Event and command control codes per port
// (R13) Slave polling control and status codes
// (R14) Time set/get, warm and cold restart
// (R15) Continuous upload and download ranges by start/count
// (R16) Ordered power-up initialisation steps
// (R17) Slave status reply: echo, index, sixty words
// (R18) Unknown codes write nothing, sequence continues
// (R19) Paging after init; payload fixed until restart
module bbp_device (
  input  wire logic        clk,
  input  wire logic        nrst,
  bbp_link_if.dev          link,
  input  wire logic [1:0]  cfg_size,
  input  wire logic [12:0] cfg_rd_start,
  input  wire logic [12:0] cfg_rd_count,
  input  wire logic [12:0] cfg_wr_start,
  input  wire logic [12:0] cfg_wr_count,
  input  wire logic        break_req,
  input  wire logic        db_rd,
  input  wire logic [12:0] db_addr,
  output logic [15:0]      db_rdata,
  output logic             init_done,
  output logic             spec_valid,
  output logic [15:0]      spec_code,
  output logic [31:0]      module_time
);
  typedef enum logic [9:0] {
    D_HW = 10'h001, D_BP = 10'h002, D_CLR = 10'h004, D_SER = 10'h008,
    D_CFG = 10'h010, D_REG = 10'h020, D_SLV = 10'h040, D_MST = 10'h080,
    D_SEND = 10'h100, D_RECV = 10'h200
  } bbp_dstate_type;
  typedef struct packed {
    bbp_dstate_type st;
    logic           cold;
    logic [12:0]    cnt;
    logic [7:0]     n;
    logic [12:0]    rd_start;
    logic [12:0]    rd_cnt;
    logic [12:0]    wr_start;
    logic [12:0]    wr_cnt;
    logic [12:0]    rd_rem;
    logic [12:0]    wr_rem;
    logic [7:0]     rd_blk;
    logic [7:0]     wr_blk;
    logic [7:0]     up;
    logic [7:0]     dn;
    logic           special;
    logic [15:0]    reply;
    logic [15:0]    rx_code;
    logic           brk;
    logic [31:0]    tm;
    logic           in_valid;
    logic           in_last;
    logic [15:0]    in_data;
    logic           spec_valid;
    logic [15:0]    spec_code;
    logic [15:0]    rdata;
  } bbp_dev_type;

  bbp_dev_type s_reg;
  bbp_dev_type s_next;
  logic [15:0] db_mem [0:bbp_pkg::DB_DEPTH-1]; // R01
  logic        mem_we;
  logic [12:0] mem_wa;
  logic [15:0] mem_wd;
  logic [12:0] ra;
  logic        rv;
  logic [15:0] rw;
  logic [15:0] off;
  logic [12:0] k;
  logic [15:0] code0;
  logic [15:0] rx;

  // Link-side read port; addresses past the map read as zero
  assign rw = (rv && ra <= bbp_pkg::CFG_LAST) ? db_mem[ra] : '0;

  always_comb begin
    s_next = s_reg;
    s_next.in_valid = 1'b0;
    s_next.in_last = 1'b0;
    s_next.spec_valid = 1'b0;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    ra = '0;
    rv = 1'b0;
    off = '0;
    k = '0;
    code0 = '0;
    rx = s_reg.rx_code;
    if (db_rd) begin
      s_next.rdata = (db_addr <= bbp_pkg::CFG_LAST) ? db_mem[db_addr] : '0;
    end
    case (s_reg.st)
      // Power-up steps run in a fixed order
      D_HW:  s_next.st = D_BP; // R16
      D_BP: begin
        s_next.cnt = '0;
        s_next.st = s_reg.cold ? D_CLR : D_SER; // R16
      end
      D_CLR: begin
        // Cold start only: a warm restart keeps the database
        mem_we = 1'b1;
        mem_wa = s_reg.cnt;
        s_next.cnt = s_reg.cnt + 13'h0001;
        if (s_reg.cnt == bbp_pkg::CFG_LAST) begin
          s_next.st = D_SER; // R16
        end
      end
      D_SER: s_next.st = D_CFG; // R16
      D_CFG: begin
        // Size and ranges are latched here and held until restart
        s_next.n = bbp_pkg::pay_len(cfg_size); // R02 R19
        s_next.rd_start = cfg_rd_start; // R15
        s_next.rd_cnt = cfg_rd_count;
        s_next.wr_start = cfg_wr_start;
        s_next.wr_cnt = cfg_wr_count;
        s_next.rd_rem = cfg_rd_count;
        s_next.wr_rem = cfg_wr_count;
        s_next.rd_blk = '0;
        s_next.wr_blk = '0;
        s_next.st = D_REG;
      end
      D_REG: begin
        // Block counts by repeated subtraction, avoiding a divider
        if (s_reg.rd_rem != '0) begin
          s_next.rd_blk = s_reg.rd_blk + 8'h01;
          s_next.rd_rem = (s_reg.rd_rem > {5'h00, s_reg.n}) ?
                          s_reg.rd_rem - {5'h00, s_reg.n} : '0;
        end
        if (s_reg.wr_rem != '0) begin
          s_next.wr_blk = s_reg.wr_blk + 8'h01;
          s_next.wr_rem = (s_reg.wr_rem > {5'h00, s_reg.n}) ?
                          s_reg.wr_rem - {5'h00, s_reg.n} : '0;
        end
        if (s_reg.rd_rem == '0 && s_reg.wr_rem == '0) begin
          s_next.st = D_SLV; // R16
        end
      end
      D_SLV: s_next.st = D_MST; // R16
      D_MST: begin
        s_next.up = (s_reg.rd_blk != '0) ? 8'h01 : 8'h00;
        s_next.dn = (s_reg.wr_blk != '0) ? 8'h01 : 8'h00;
        s_next.special = 1'b0;
        s_next.cnt = '0;
        s_next.st = D_SEND; // R19
      end
      D_SEND: begin
        s_next.in_valid = 1'b1;
        s_next.cnt = s_reg.cnt + 13'h0001;
        k = s_reg.cnt - {5'h00, bbp_pkg::IN_HDR};
        code0 = s_reg.special ? s_reg.reply : {8'h00, s_reg.up};
        if (s_reg.cnt == 13'h0000) begin
          // Pending command request turns a regular image into a status block; at a special reply image it is cleared unused
          if (s_reg.brk && !s_reg.special) begin
            s_next.special = 1'b1; // R10
            s_next.reply = bbp_pkg::C_STAT0;
            code0 = bbp_pkg::C_STAT0;
          end
          s_next.brk = 1'b0;
          s_next.in_data = code0; // R05
        end else if (s_reg.cnt == 13'h0001) begin
          s_next.in_data = {8'h00, s_reg.dn}; // R05 R17
        end else begin
          if (!s_reg.special) begin
            if (s_reg.up == 8'h00) begin
              ra = bbp_pkg::CFG_FIRST + k;
              rv = 1'b1;
            end else begin
              off = 16'({8'h00, s_reg.up - 8'h01} * {8'h00, s_reg.n}) + {3'h0, k};
              ra = s_reg.rd_start + off[12:0]; // R15
              rv = (off < {3'h0, s_reg.rd_cnt});
            end
          end else if (s_reg.reply >= bbp_pkg::C_SS1 && s_reg.reply <= bbp_pkg::C_SS1_END) begin
            ra = bbp_pkg::SLV1_BASE + 13'((s_reg.reply - bbp_pkg::C_SS1) * 16'(bbp_pkg::SLV_WORDS)) + k;
            rv = (k < {5'h00, bbp_pkg::SLV_WORDS}); // R17
          end else if (s_reg.reply >= bbp_pkg::C_SS2 && s_reg.reply <= bbp_pkg::C_SS2_END) begin
            ra = bbp_pkg::SLV2_BASE + 13'((s_reg.reply - bbp_pkg::C_SS2) * 16'(bbp_pkg::SLV_WORDS)) + k;
            rv = (k < {5'h00, bbp_pkg::SLV_WORDS}); // R17
          end else if (s_reg.reply == bbp_pkg::C_STAT0 || s_reg.reply == bbp_pkg::C_STAT_M1) begin
            ra = bbp_pkg::CFG_FIRST + k; // R11
            rv = 1'b1;
          end
          s_next.in_data = rw; // R05
          if (s_reg.special && s_reg.reply == bbp_pkg::C_TGET) begin
            s_next.in_data = (k == 13'h0000) ? s_reg.tm[31:16] :
                             (k == 13'h0001) ? s_reg.tm[15:0] : '0; // R14
          end
        end
        if (s_reg.cnt == {5'h00, s_reg.n} + {5'h00, bbp_pkg::IN_HDR} - 13'h0001) begin
          s_next.in_last = 1'b1; // R03
          s_next.cnt = '0;
          s_next.st = D_RECV;
          s_next.special = 1'b0;
          if (!s_next.special && s_reg.rd_blk != '0 && !(s_reg.special)) begin
            s_next.up = (s_reg.up == s_reg.rd_blk) ? 8'h01 : s_reg.up + 8'h01; // R09
          end
        end
      end
      D_RECV: begin
        if (link.out_valid) begin
          s_next.cnt = s_reg.cnt + 13'h0001;
          k = s_reg.cnt - {5'h00, bbp_pkg::OUT_HDR};
          if (s_reg.cnt == 13'h0000) begin
            s_next.rx_code = link.out_data;
          end else if (rx != 16'h0000 && rx <= bbp_pkg::C_DATA_LAST &&
                       rx[7:0] <= s_reg.wr_blk && rx[15:8] == 8'h00) begin // R18
            // Page write, cut to the per-transfer limit
            off = 16'({8'h00, rx[7:0] - 8'h01} * {8'h00, s_reg.n}) + {3'h0, k};
            mem_wa = s_reg.wr_start + off[12:0];
            mem_wd = link.out_data;
            mem_we = (k < {5'h00, s_reg.n}) && (k < {5'h00, bbp_pkg::MAX_WR}) &&
                     (off < {3'h0, s_reg.wr_cnt}) && (mem_wa <= bbp_pkg::CFG_LAST); // R08 R15
          end else if (rx == bbp_pkg::C_TSET) begin
            if (k == 13'h0000) s_next.tm[31:16] = link.out_data; // R14
            if (k == 13'h0001) s_next.tm[15:0] = link.out_data;
          end
          if (link.out_last) begin
            s_next.cnt = '0;
            s_next.st = D_SEND;
            if (s_reg.wr_blk != '0) begin
              s_next.dn = (s_reg.dn == s_reg.wr_blk) ? 8'h01 : s_reg.dn + 8'h01; // R09
            end
            if (rx != 16'h0000 && rx <= bbp_pkg::C_DATA_LAST &&
                rx[7:0] <= s_reg.wr_blk && rx[15:8] == 8'h00) begin
              // Resume the request order after the page actually received
              s_next.dn = (rx[7:0] == s_reg.wr_blk) ? 8'h01 : rx[7:0] + 8'h01; // R10
            end else if ((rx >= bbp_pkg::C_POLL1 && rx <= bbp_pkg::C_SS1_END) ||
                         (rx >= bbp_pkg::C_POLL2 && rx <= bbp_pkg::C_SS2_END) ||
                         rx == bbp_pkg::C_TGET) begin
              s_next.special = 1'b1; // R13 R17
              s_next.reply = rx;
              s_next.spec_valid = (rx <= bbp_pkg::C_POLL1_END) ||
                                  (rx >= bbp_pkg::C_POLL2 && rx <= bbp_pkg::C_POLL2_END);
              s_next.spec_code = rx;
            end else if (rx == bbp_pkg::C_EV1 || rx == bbp_pkg::C_EV2 ||
                         (rx >= bbp_pkg::C_CMD1 && rx <= bbp_pkg::C_CMD1_END) ||
                         (rx >= bbp_pkg::C_CMD2 && rx <= bbp_pkg::C_CMD2_END)) begin
              s_next.spec_valid = 1'b1; // R12
              s_next.spec_code = rx;
            end else if (rx == bbp_pkg::C_WARM || rx == bbp_pkg::C_COLD) begin
              s_next.cold = (rx == bbp_pkg::C_COLD); // R14
              s_next.st = D_HW;
            end
            // Status codes and unknown codes fall through with no write R18
          end
        end
      end
      default: s_next.st = D_HW;
    endcase
    // Request set wins over the clear taken at image start
    if (break_req) begin
      s_next.brk = 1'b1; // R10
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.st <= D_HW;
      s_reg.cold <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Database write port, no reset on storage
  always_ff @(posedge clk) begin
    if (mem_we) begin
      db_mem[mem_wa] <= mem_wd;
    end
  end

  assign link.in_valid = s_reg.in_valid;
  assign link.in_data  = s_reg.in_data;
  assign link.in_last  = s_reg.in_last;
  assign db_rdata      = s_reg.rdata;
  assign init_done     = (s_reg.st == D_SEND) || (s_reg.st == D_RECV);
  assign spec_valid    = s_reg.spec_valid;
  assign spec_code     = s_reg.spec_code;
  assign module_time   = s_reg.tm;
endmodule : bbp_device
`default_nettype wire

/* File: test/bbp_link_assertions.sv */
// Protocol checker for the image link between the pager and its host end
`default_nettype none
module bbp_link_assertions #(
  parameter int N         = 60,
  parameter int RD_BLOCKS = 2,
  parameter int WR_BLOCKS = 2
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        in_valid,
  input wire logic [15:0] in_data,
  input wire logic        in_last,
  input wire logic        out_valid,
  input wire logic [15:0] out_data,
  input wire logic        out_last,
  input wire logic        init_done
);
  logic [8:0] in_cnt_reg;
  logic [8:0] out_cnt_reg;
  logic [15:0] out_code_reg;
  logic        restart_code;

  // A restart code legally stops paging while the device re-initialises
  assign restart_code = (out_code_reg == bbp_pkg::C_WARM) || (out_code_reg == bbp_pkg::C_COLD);

  // Word position inside the current image, so framing is judged by count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_cnt_reg  <= 9'h000;
      out_cnt_reg <= 9'h000;
      out_code_reg <= 16'h0000;
    end else begin
      if (out_valid && out_cnt_reg == 9'h000) out_code_reg <= out_data;
      if (in_valid) in_cnt_reg <= in_last ? 9'h000 : in_cnt_reg + 9'h001;
      if (out_valid) out_cnt_reg <= out_last ? 9'h000 : out_cnt_reg + 9'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_host_done;
    out_valid && out_last && !restart_code;
  endsequence
  sequence s_dev_next;
    ##[1:2] (in_valid && !in_last);
  endsequence
  sequence s_dev_done;
    in_valid && in_last;
  endsequence

  property p_in_len;
    in_last |-> in_valid && (in_cnt_reg == 9'(N + 1));
  endproperty
  a_in_len: assert property (p_in_len) else $error("input image length wrong");
  property p_in_cont;
    in_valid && !in_last |=> in_valid;
  endproperty
  a_in_cont: assert property (p_in_cont) else $error("input image has a gap");
  property p_out_len;
    out_last |-> out_valid && (out_cnt_reg == 9'(N));
  endproperty
  a_out_len: assert property (p_out_len) else $error("output image length wrong");
  property p_alternate;
    in_valid |-> !out_valid;
  endproperty
  a_alternate: assert property (p_alternate) else $error("images overlap");
  property p_turn;
    s_host_done |-> s_dev_next;
  endproperty
  a_turn: assert property (p_turn) else $error("device did not resume sending");
  property p_host_answer;
    s_dev_done |-> ##2 out_valid;
  endproperty
  a_host_answer: assert property (p_host_answer) else $error("host reply late");
  property p_init_gate;
    !init_done |-> !in_valid;
  endproperty
  a_init_gate: assert property (p_init_gate) else $error("paging before init");
  property p_init_keep;
    init_done && !(out_valid && out_last && restart_code) |=> init_done;
  endproperty
  a_init_keep: assert property (p_init_keep) else $error("paging stopped");
  property p_dn_index;
    in_valid && in_cnt_reg == 9'h001 |-> in_data <= 16'(WR_BLOCKS);
  endproperty
  a_dn_index: assert property (p_dn_index) else $error("download index out of range");
  property p_up_index;
    in_valid && in_cnt_reg == 9'h000 |-> in_data <= 16'(RD_BLOCKS) || in_data >= 16'h03e8;
  endproperty
  a_up_index: assert property (p_up_index) else $error("upload index out of range");
endmodule : bbp_link_assertions
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench joining device and host ends over the image link
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        break_req = 1'b0;
  logic        db_rd = 1'b0;
  logic [12:0] db_addr = 13'h0000;
  logic [15:0] db_rdata;
  logic        init_done;
  logic        spec_valid;
  logic [15:0] spec_code;
  logic [31:0] module_time;
  // One size setting feeds both ends; the host rereads it every image, the device only at init
  logic [1:0]  cfg_size = bbp_pkg::SZ_60;
  logic [12:0] cfg_rd_count = 13'h0078;
  int          fails = 0;
  int          comparisons = 0;

  // Half period of 2 ns gives the 250 MHz clock
  always #2 clk = ~clk;

  bbp_link_if link ();
  bbp_device bbp_device_inst (.clk(clk), .nrst(nrst), .link(link), .cfg_size(cfg_size),
    .cfg_rd_start(13'h01e0), .cfg_rd_count(cfg_rd_count), .cfg_wr_start(13'h01e0),
    .cfg_wr_count(13'h0078), .break_req(break_req), .db_rd(db_rd), .db_addr(db_addr),
    .db_rdata(db_rdata), .init_done(init_done), .spec_valid(spec_valid),
    .spec_code(spec_code), .module_time(module_time));
  bbp_host bbp_host_inst (.clk(clk), .nrst(nrst), .link(link), .cfg_size(cfg_size),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  bbp_link_assertions #(.N(60), .RD_BLOCKS(2), .WR_BLOCKS(2)) bbp_link_assertions_inst (
    .clk(clk), .nrst(nrst), .in_valid(link.in_valid), .in_data(link.in_data),
    .in_last(link.in_last), .out_valid(link.out_valid), .out_data(link.out_data),
    .out_last(link.out_last), .init_done(init_done));

  task automatic give_verdict;
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, seen, exp);
    end
  endtask : chk

  // Host software port: one-cycle strobes, read data in the following cycle
  task automatic hw(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : hw

  task automatic hr(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : hr

  task automatic dbr(input logic [12:0] a, output logic [15:0] d);
    @(posedge clk);
    db_rd <= 1'b1;
    db_addr <= a;
    @(posedge clk);
    db_rd <= 1'b0;
    #1 d = db_rdata;
  endtask : dbr

  // Polls a host register; a bound keeps a dead link from hanging the run
  task automatic wait_eq(input logic [11:0] a, input logic [15:0] v);
    logic [15:0] r;
    for (int i = 0; i < 400; i++) begin
      hr(a, r);
      if (r === v) return;
      repeat (20) @(posedge clk);
    end
    chk(r, v, "host register never reached value");
    give_verdict();
  endtask : wait_eq

  initial begin
    logic [15:0] v;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    // Host pages can be loaded while the device still initialises
    for (int k = 0; k < 120; k++) hw(12'(k), 16'ha000 + 16'(k));
    for (int i = 0; i < 20000 && init_done !== 1'b1; i++) @(posedge clk);
    chk(init_done, 1, "init never completed");
    if (init_done !== 1'b1) give_verdict();
    wait_eq(bbp_pkg::HR_COUNT, 16'h0008);
    // Download pages land at start + (index-1)*n + k, uploads carry them back
    for (int k = 0; k < 120; k++) begin
      dbr(13'h01e0 + 13'(k), v);
      chk(v, 16'ha000 + 16'(k), "database word after download");
      hr(12'h400 + 12'(k), v);
      chk(v, 16'ha000 + 16'(k), "host copy of upload page");
    end
    dbr(13'h1f40, v);
    chk(v, 0, "read past database end");
    hr(12'h900, v);
    chk(v, 0, "unmapped host read");
    hw(12'h400, 16'h5555);
    hr(12'h400, v);
    chk(v, 16'ha000, "received area must stay read-only");
    // Special block sets module time from the first two payload words
    hw(12'h000, 16'h1234);
    hw(12'h001, 16'h5678);
    hw(bbp_pkg::HR_SPEC, bbp_pkg::C_TSET);
    wait_eq(bbp_pkg::HR_STAT, 16'h0000);
    repeat (300) @(posedge clk);
    chk(module_time, 32'h12345678, "module time after set block");
    // A break request slips a status block into the upload sequence
    break_req <= 1'b1;
    @(posedge clk);
    break_req <= 1'b0;
    wait_eq(bbp_pkg::HR_LAST, 16'h0000);
    wait_eq(bbp_pkg::HR_LAST, 16'h0001);
    // Special replies echo their code where the upload index stands
    hw(bbp_pkg::HR_SPEC, bbp_pkg::C_TGET);
    wait_eq(bbp_pkg::HR_LAST, bbp_pkg::C_TGET);
    hw(bbp_pkg::HR_SPEC, bbp_pkg::C_SS1);
    wait_eq(bbp_pkg::HR_LAST, bbp_pkg::C_SS1);
    // Event pulse lasts one cycle; the falling edge sees it settled
    hw(bbp_pkg::HR_SPEC, bbp_pkg::C_EV1);
    for (int i = 0; i < 2000 && spec_valid !== 1'b1; i++) @(negedge clk);
    chk(spec_valid, 1, "event request pulse");
    if (spec_valid !== 1'b1) give_verdict();
    chk(spec_code, bbp_pkg::C_EV1, "event request code");
    // Warm restart re-runs init, then paging resumes
    hw(bbp_pkg::HR_SPEC, bbp_pkg::C_WARM);
    wait_eq(bbp_pkg::HR_STAT, 16'h0000);
    repeat (300) @(posedge clk);
    chk(init_done, 1, "paging after warm restart");
    dbr(13'h01e2, v);
    chk(v, 16'ha002, "database after warm restart");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
